// ==== core/page_protection_lock_fault_consts.vh ====
`ifndef PAGE_PROTECTION_LOCK_FAULT_CONSTS_VH
`define PAGE_PROTECTION_LOCK_FAULT_CONSTS_VH
// register byte addresses
`define ADDR_FAULT_ADDRESS 32'h0184a000
`define ADDR_FAULT_STATUS 32'h0184a004
`define ADDR_FAULT_CLEAR 32'h0184a008
`define ADDR_LOCK_KEY_WORD0 32'h0184a100
`define ADDR_LOCK_KEY_WORD1 32'h0184a104
`define ADDR_LOCK_KEY_WORD2 32'h0184a108
`define ADDR_LOCK_KEY_WORD3 32'h0184a10c
`define ADDR_LOCK_COMMAND 32'h0184a110
`define ADDR_LOCK_STATE 32'h0184a114
// page attribute words: base plus four times the page index
`define ADDR_PAGE_BASE_HI 24'h0184a2
`define PAGE_IDX_W 6
// page attribute fields
`define PA_GRANT_ID0 10
`define PA_GRANT_OTHERS 9
`define PA_GRANT_LOCAL 8
`define PA_SUP_READ 5
`define PA_SUP_WRITE 4
`define PA_SUP_EXEC 3
`define PA_USR_READ 2
`define PA_USR_WRITE 1
`define PA_USR_EXEC 0
`define PA_NUM_ID_GRANTS 6
`define PA_DEFAULT 16'hffff
// lock command fields
`define CMD_UNLOCK 0
`define CMD_LOCK 1
`define CMD_KEY_RESET 2
// fault status fields
`define FS_ID_LSB 9
`define FS_ID_W 7
`define FS_LOCAL 8
`define FS_SUP_READ 5
`define FS_SUP_WRITE 4
`define FS_USR_READ 2
`define FS_USR_WRITE 1
`define FAULT_CLEAR_BIT 0
`endif

// ==== core/page_protection_lock_fault.v ====
// Function
// - bits 15:10 grant or deny requestor ids 5 down to 0
// - bit 9 grants or denies all requestor ids of 6 and above
// - bit 8 grants or denies cpu local accesses to the page
// - bits 5:0 permit supervisor and user read, write, execute
// - page words read/write, reset value taken from configuration input
// - key words 0 and 1 hold key bits 31:0 and 63:32, write only
// - only a 64-bit key is implemented
// - writes to key words 2 and 3 are ignored
// - command bit 1 locks after a correct sequence, bit 2 resets the key entry
// - command bit 0 unlocks after a correct sequence
// - lock state bit 0 shows lock engaged, upper bits read zero
// - fault information is kept in dedicated registers
// - fault address holds the full faulting address
// - fault status bits 15:9 hold faulting id bits 6:0
// - narrow ids zero extend, wide ids are truncated
// - fault status bit 8 marks a local fault, id field then zero
// - bits 5 and 4 mark supervisor read and write, reset zero
// - bits 2 and 1 mark user read and write, bits 3 and 0 zero
// - writing 1 to fault clear bit 0 clears address and status
// - first fault kept, local may replace remote, held until cleared
`timescale 1ns/1ps
`include "page_protection_lock_fault_consts.vh"
`default_nettype none

module page_protection_lock_fault #(
  parameter NUM_PAGES = 64,
  parameter PAGE_SHIFT = 15,
  parameter ID_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire [15:0] page_reset_cfg,
  input wire acc_valid,
  input wire [31:0] acc_addr,
  input wire [ID_W-1:0] acc_id,
  input wire acc_local,
  input wire acc_super,
  input wire acc_read,
  input wire acc_write,
  input wire acc_exec,
  output wire acc_grant,
  output wire fault_exception,
  output wire lock_engaged
);

  reg [15:0] page_ff [0:NUM_PAGES-1];
  reg cfg_loaded_ff;
  reg [31:0] prdata_ff;
  reg [63:0] key_entry_ff;
  reg [63:0] key_stored_ff;
  reg [1:0] key_written_ff;
  reg lock_engaged_ff;
  reg [31:0] fault_address_ff;
  reg [15:0] fault_status_ff;
  reg fault_valid_ff;
  reg fault_exception_ff;

  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr_en = access_phase & pwrite;

  // address decode
  wire hit_fault_address = (paddr == `ADDR_FAULT_ADDRESS);
  wire hit_fault_status = (paddr == `ADDR_FAULT_STATUS);
  wire hit_fault_clear = (paddr == `ADDR_FAULT_CLEAR);
  wire hit_key0 = (paddr == `ADDR_LOCK_KEY_WORD0);
  wire hit_key1 = (paddr == `ADDR_LOCK_KEY_WORD1);
  wire hit_key2 = (paddr == `ADDR_LOCK_KEY_WORD2);
  wire hit_key3 = (paddr == `ADDR_LOCK_KEY_WORD3);
  wire hit_cmd = (paddr == `ADDR_LOCK_COMMAND);
  wire hit_state = (paddr == `ADDR_LOCK_STATE);
  wire [`PAGE_IDX_W-1:0] reg_page_idx = paddr[`PAGE_IDX_W+1:2];
  wire hit_page = (paddr[31:8] == `ADDR_PAGE_BASE_HI) && (paddr[1:0] == 2'b00)
                  && ({26'h0, reg_page_idx} < NUM_PAGES);
  wire hit_any = hit_fault_address | hit_fault_status | hit_fault_clear | hit_key0 |
                 hit_key1 | hit_key2 | hit_key3 | hit_cmd | hit_state | hit_page;
  // page words cannot be changed while the lock is engaged
  wire page_wr_blocked = hit_page & pwrite & lock_engaged_ff;

  assign pready = 1'b1;
  assign pslverr = access_phase & (~hit_any | page_wr_blocked);
  assign prdata = prdata_ff;
  assign lock_engaged = lock_engaged_ff;
  assign fault_exception = fault_exception_ff;

  // read data is gathered in the setup cycle and stands in the access cycle
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    if (hit_fault_address) begin
      rd_mux = fault_address_ff;
    end else if (hit_fault_status) begin
      rd_mux = {16'h0, fault_status_ff};
    end else if (hit_state) begin
      rd_mux = {31'h0, lock_engaged_ff};
    end else if (hit_page) begin
      rd_mux = {16'h0, page_ff[reg_page_idx]};
    end
  end

  reg [31:0] nxt_prdata;
  always @* begin
    nxt_prdata = prdata_ff;
    if (setup_phase && !pwrite) begin
      nxt_prdata = rd_mux;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // access check against the page word of the target page
  wire [`PAGE_IDX_W-1:0] acc_page_idx = acc_addr[PAGE_SHIFT+`PAGE_IDX_W-1:PAGE_SHIFT];
  wire acc_page_ok = ({26'h0, acc_page_idx} < NUM_PAGES);
  wire [15:0] acc_attr = acc_page_ok ? page_ff[acc_page_idx] : 16'h0;

  reg id_ok;
  reg type_ok;
  always @* begin
    id_ok = 1'b0;
    if (acc_local) begin
      id_ok = acc_attr[`PA_GRANT_LOCAL];
    end else if ({{32{1'b0}}, acc_id} < `PA_NUM_ID_GRANTS) begin
      id_ok = acc_attr[`PA_GRANT_ID0 + acc_id[2:0]];
    end else begin
      id_ok = acc_attr[`PA_GRANT_OTHERS];
    end
  end

  always @* begin
    type_ok = 1'b1;
    if (acc_super) begin
      if (acc_read && !acc_attr[`PA_SUP_READ]) begin
        type_ok = 1'b0;
      end
      if (acc_write && !acc_attr[`PA_SUP_WRITE]) begin
        type_ok = 1'b0;
      end
      if (acc_exec && !acc_attr[`PA_SUP_EXEC]) begin
        type_ok = 1'b0;
      end
    end else begin
      if (acc_read && !acc_attr[`PA_USR_READ]) begin
        type_ok = 1'b0;
      end
      if (acc_write && !acc_attr[`PA_USR_WRITE]) begin
        type_ok = 1'b0;
      end
      if (acc_exec && !acc_attr[`PA_USR_EXEC]) begin
        type_ok = 1'b0;
      end
    end
  end

  assign acc_grant = id_ok & type_ok;
  wire acc_violation = acc_valid & ~acc_grant;

  // faulting id, zero extended or truncated to seven bits
  reg [`FS_ID_W-1:0] fault_id;
  integer b;
  always @* begin
    fault_id = {`FS_ID_W{1'b0}};
    for (b = 0; b < `FS_ID_W; b = b + 1) begin
      if (b < ID_W) begin
        fault_id[b] = acc_id[b];
      end
    end
  end

  wire [15:0] fault_word;
  assign fault_word = {
    (acc_local ? {`FS_ID_W{1'b0}} : fault_id),
    acc_local,
    2'b00,
    acc_super & acc_read,
    acc_super & acc_write,
    1'b0,
    ~acc_super & acc_read,
    ~acc_super & acc_write,
    1'b0
  };

  // first fault wins; a local one may replace a recorded remote one
  wire fault_take = acc_violation &
                    (~fault_valid_ff | (~fault_status_ff[`FS_LOCAL] & acc_local));
  wire fault_clr = wr_en & hit_fault_clear & pwdata[`FAULT_CLEAR_BIT];

  // next fault record; a fault that is taken beats a clear in the same cycle
  reg [31:0] nxt_fault_address;
  reg [15:0] nxt_fault_status;
  reg nxt_fault_valid;
  always @* begin
    nxt_fault_address = fault_address_ff;
    nxt_fault_status = fault_status_ff;
    nxt_fault_valid = fault_valid_ff;
    if (fault_take) begin
      nxt_fault_address = acc_addr;
      nxt_fault_status = fault_word;
      nxt_fault_valid = 1'b1;
    end else if (fault_clr) begin
      nxt_fault_address = 32'h0;
      nxt_fault_status = 16'h0;
      nxt_fault_valid = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_address_ff <= 32'h0;
      fault_status_ff <= 16'h0;
      fault_valid_ff <= 1'b0;
      fault_exception_ff <= 1'b0;
    end else begin
      fault_exception_ff <= fault_take;
      fault_address_ff <= nxt_fault_address;
      fault_status_ff <= nxt_fault_status;
      fault_valid_ff <= nxt_fault_valid;
    end
  end

  // key entry and lock state
  wire cmd_wr = wr_en & hit_cmd;
  wire cmd_unlock = cmd_wr & pwdata[`CMD_UNLOCK];
  wire cmd_lock = cmd_wr & pwdata[`CMD_LOCK];
  wire cmd_key_reset = cmd_wr & pwdata[`CMD_KEY_RESET];
  wire key_complete = &key_written_ff;
  wire key_match = (key_entry_ff == key_stored_ff);

  localparam LOCK_OPEN = 1'b0;
  localparam LOCK_SHUT = 1'b1;

  reg [63:0] nxt_key_entry;
  reg [63:0] nxt_key_stored;
  reg [1:0] nxt_key_written;
  reg nxt_lock_engaged;

  // entered words count only since the last command; words 2 and 3 are not stored
  always @* begin
    nxt_key_entry = key_entry_ff;
    nxt_key_written = key_written_ff;
    if (wr_en && hit_key0) begin
      nxt_key_entry[31:0] = pwdata;
      nxt_key_written[0] = 1'b1;
    end
    if (wr_en && hit_key1) begin
      nxt_key_entry[63:32] = pwdata;
      nxt_key_written[1] = 1'b1;
    end
    if (cmd_key_reset) begin
      nxt_key_entry = 64'h0;
      nxt_key_written = 2'b00;
    end else if (cmd_lock || cmd_unlock) begin
      nxt_key_written = 2'b00;
    end
  end

  // command priority: key reset, then lock, then unlock
  always @* begin
    nxt_lock_engaged = lock_engaged_ff;
    nxt_key_stored = key_stored_ff;
    case (lock_engaged_ff)
      LOCK_OPEN: begin
        if (cmd_lock && !cmd_key_reset && key_complete) begin
          nxt_lock_engaged = LOCK_SHUT;
          nxt_key_stored = key_entry_ff;
        end
      end
      LOCK_SHUT: begin
        if (cmd_unlock && !cmd_lock && !cmd_key_reset && key_complete && key_match) begin
          nxt_lock_engaged = LOCK_OPEN;
        end
      end
      default: begin
        nxt_lock_engaged = LOCK_OPEN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_entry_ff <= 64'h0;
      key_stored_ff <= 64'h0;
      key_written_ff <= 2'b00;
      lock_engaged_ff <= LOCK_OPEN;
    end else begin
      key_entry_ff <= nxt_key_entry;
      key_stored_ff <= nxt_key_stored;
      key_written_ff <= nxt_key_written;
      lock_engaged_ff <= nxt_lock_engaged;
    end
  end

  // page words: constant at reset, configuration value caught after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_ff <= 1'b0;
    end else begin
      cfg_loaded_ff <= 1'b1;
    end
  end

  // write merge honours the two low byte strobes
  wire page_wr = wr_en & hit_page & ~lock_engaged_ff;
  reg [15:0] nxt_page_word;
  always @* begin
    nxt_page_word = page_ff[reg_page_idx];
    if (pstrb[0]) begin
      nxt_page_word[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      nxt_page_word[15:8] = pwdata[15:8];
    end
  end

  integer p;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (p = 0; p < NUM_PAGES; p = p + 1) begin
        page_ff[p] <= `PA_DEFAULT;
      end
    end else if (!cfg_loaded_ff) begin
      for (p = 0; p < NUM_PAGES; p = p + 1) begin
        page_ff[p] <= page_reset_cfg;
      end
    end else if (page_wr) begin
      page_ff[reg_page_idx] <= nxt_page_word;
    end
  end

endmodule // page_protection_lock_fault
`default_nettype wire

// ==== tb/ppl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "page_protection_lock_fault_consts.vh"
module ppl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic acc_valid,
  input wire logic acc_grant,
  input wire logic fault_exception,
  input wire logic lock_engaged
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_ph = psel && penable;
  wire rd_setup = psel && !penable && !pwrite;
  a_ready_access: assert property (acc_ph |-> pready)
    else $error("no ready in access phase");
  a_err_phase: assert property (pslverr |-> acc_ph)
    else $error("slave error outside access phase");
  a_exc_cause: assert property (fault_exception |-> $past(acc_valid && !acc_grant))
    else $error("exception without a denied access");
  a_lock_cause: assert property ($changed(lock_engaged) |-> $past(acc_ph && pwrite && paddr == `ADDR_LOCK_COMMAND))
    else $error("lock changed without a command");
  a_locked_page: assert property (acc_ph && pwrite && lock_engaged && paddr[31:8] == `ADDR_PAGE_BASE_HI |-> pslverr)
    else $error("page write accepted while locked");
  a_key_hi_ok: assert property (acc_ph && (paddr == `ADDR_LOCK_KEY_WORD2 || paddr == `ADDR_LOCK_KEY_WORD3) |-> !pslverr)
    else $error("upper key word refused");
  a_state_read: assert property (rd_setup && paddr == `ADDR_LOCK_STATE |=> prdata == {31'h0, $past(lock_engaged)})
    else $error("lock state read wrong");
  a_wo_zero: assert property (rd_setup && paddr == `ADDR_LOCK_COMMAND |=> prdata == 32'h0)
    else $error("write only register read not zero");
  a_unmapped_err: assert property (acc_ph && paddr == 32'h0184a00c |-> pslverr)
    else $error("unmapped access not refused");
endmodule // ppl_chk
bind page_protection_lock_fault ppl_chk i_ppl_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .prdata, .pslverr, .acc_valid, .acc_grant, .fault_exception, .lock_engaged);
`default_nettype wire

// ==== tb/requestor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module requestor_model (
  input wire logic pclk,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic [7:0] acc_id,
  output logic acc_local,
  output logic acc_super,
  output logic [2:0] acc_type
);
  initial {acc_valid, acc_addr, acc_id, acc_local, acc_super, acc_type} = '0;
  // one access per call; an idle address bus shows the inverse of its last value
  task automatic issue(input logic v, input logic [31:0] a, input logic [7:0] id,
    input logic l, input logic s, input logic [2:0] t);
    @(posedge pclk);
    acc_valid <= v;
    acc_addr <= v ? a : ~acc_addr;
    {acc_id, acc_local, acc_super, acc_type} <= {id, l, s, t};
    #1;
  endtask
endmodule // requestor_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "page_protection_lock_fault_consts.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, acc_valid, acc_local, acc_super;
  logic acc_grant, fault_exception, lock_engaged;
  logic [31:0] paddr, pwdata, prdata, acc_addr, seed, rdat, k0, k1, cfg, a1, a3;
  logic [15:0] page_reset_cfg, pa;
  logic [7:0] acc_id;
  logic [3:0] pstrb;
  logic [2:0] acc_type;
  logic [5:0] p;
  logic rerr;
  int fail_count = 0;
  int checks = 0;
  always #12.5 pclk = ~pclk;
  page_protection_lock_fault i_page_protection_lock_fault (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .page_reset_cfg, .acc_valid,
    .acc_addr, .acc_id, .acc_local, .acc_super, .acc_read(acc_type[2]),
    .acc_write(acc_type[1]), .acc_exec(acc_type[0]), .acc_grant, .fault_exception,
    .lock_engaged);
  requestor_model i_requestor_model (.pclk, .acc_valid, .acc_addr, .acc_id, .acc_local,
    .acc_super, .acc_type);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] pg_addr(logic [5:0] pg);
    logic [31:0] r;
    r = rnd();
    return {r[31:21], pg, r[14:0]};
  endfunction
  function logic exp_grant(logic [15:0] a, logic [7:0] id, logic l, logic s, logic [2:0] t);
    logic g;
    g = l ? a[8] : (id < 6 ? a[10 + id] : a[9]);
    return g && (|(t & (s ? a[5:3] : a[2:0])));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge pclk);
    fail_count++;
    print_verdict;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    seed = 32'h6661f9f7;
    cfg = rnd();
    page_reset_cfg = cfg[15:0];
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, 32'h0184a214, 0);
    chk(rdat, {16'h0, cfg[15:0]});
    apb(0, `ADDR_FAULT_STATUS, 0);
    chk(rdat, 0);
    apb(0, `ADDR_LOCK_STATE, 0);
    chk(rdat, 0);
    apb(0, `ADDR_LOCK_COMMAND, 0);
    chk(rdat, 0);
    apb(0, 32'h0184a00c, 0);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("reset test done");
    repeat (60) begin
      p = rnd();
      pa = rnd();
      apb(1, {24'h0184a2, p, 2'b00}, {16'h0, pa});
      apb(0, {24'h0184a2, p, 2'b00}, 0);
      chk(rdat, {16'h0, pa});
      i_requestor_model.issue(1, pg_addr(p), rnd() % 10, rnd(), rnd(), 3'b001 << (rnd() % 3));
      chk(acc_grant, exp_grant(pa, acc_id, acc_local, acc_super, acc_type));
      i_requestor_model.issue(0, 0, 0, 0, 0, 0);
    end
    apb(1, `ADDR_FAULT_CLEAR, 1);
    $display("grant test done");
    apb(1, `ADDR_PAGE_BASE_HI << 8, 0);
    a1 = pg_addr(0);
    i_requestor_model.issue(1, a1, 8'h85, 0, 1, 3'b010);
    i_requestor_model.issue(0, 0, 0, 0, 0, 0);
    chk(fault_exception, 1);
    apb(0, `ADDR_FAULT_ADDRESS, 0);
    chk(rdat, a1);
    apb(0, `ADDR_FAULT_STATUS, 0);
    chk(rdat, 32'h0a10);
    i_requestor_model.issue(1, pg_addr(0), 8'h03, 0, 0, 3'b100);
    i_requestor_model.issue(0, 0, 0, 0, 0, 0);
    chk(fault_exception, 0);
    a3 = pg_addr(0);
    i_requestor_model.issue(1, a3, 8'h44, 1, 0, 3'b100);
    i_requestor_model.issue(0, 0, 0, 0, 0, 0);
    chk(fault_exception, 1);
    apb(0, `ADDR_FAULT_ADDRESS, 0);
    chk(rdat, a3);
    apb(1, `ADDR_FAULT_CLEAR, 32'hfffffffe);
    apb(0, `ADDR_FAULT_STATUS, 0);
    chk(rdat, 32'h0104);
    apb(1, `ADDR_FAULT_CLEAR, 1);
    apb(0, `ADDR_FAULT_STATUS, 0);
    chk(rdat, 0);
    apb(0, `ADDR_FAULT_ADDRESS, 0);
    chk(rdat, 0);
    $display("fault test done");
    k0 = rnd();
    k1 = rnd();
    apb(1, `ADDR_LOCK_KEY_WORD0, k0);
    apb(1, `ADDR_LOCK_KEY_WORD1, k1);
    apb(1, `ADDR_LOCK_COMMAND, 32'h2);
    apb(0, `ADDR_LOCK_STATE, 0);
    chk(rdat, 1);
    apb(1, 32'h0184a204, rnd());
    chk(rerr, 1);
    apb(1, `ADDR_LOCK_KEY_WORD0, ~k0);
    apb(1, `ADDR_LOCK_KEY_WORD1, k1);
    apb(1, `ADDR_LOCK_COMMAND, 32'h1);
    @(negedge pclk);
    chk(lock_engaged, 1);
    apb(1, `ADDR_LOCK_KEY_WORD0, k0);
    apb(1, `ADDR_LOCK_COMMAND, 32'h4);
    apb(1, `ADDR_LOCK_KEY_WORD1, k1);
    apb(1, `ADDR_LOCK_COMMAND, 32'h1);
    @(negedge pclk);
    chk(lock_engaged, 1);
    apb(1, `ADDR_LOCK_KEY_WORD0, k0);
    apb(1, `ADDR_LOCK_KEY_WORD1, k1);
    apb(1, `ADDR_LOCK_KEY_WORD2, rnd());
    apb(1, `ADDR_LOCK_KEY_WORD3, rnd());
    chk(rerr, 0);
    apb(1, `ADDR_LOCK_COMMAND, 32'h1);
    apb(0, `ADDR_LOCK_STATE, 0);
    chk(rdat, 0);
    $display("lock test done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
